//--- sadc_dev.sv
/*
  Converter end of the link: mode selection, internally timed conversion
  and serial readout in three-wire, four-wire and daisy-chain modes.
  Assumes the link pins arrive unsynchronised from the host and that
  sample_i carries the analog input already quantised by the bench.
*/
// What this block and its host do
// RQ1: Convert rise samples data input for mode.
// RQ2: Conversion timed internally, serial clock reads only.
// RQ3: Result is straight binary, unipolar full scale.
// RQ4: Three-wire convert rise tristates, samples, converts.
// RQ5: Three-wire conversion ignores later convert levels.
// RQ6: Host returns convert high within conversion window.
// RQ7: Three-wire convert fall shows MSB, falls shift.
// RQ8: Three-wire release at 16th fall or rise.
// RQ9: Four-wire host holds convert high until read.
// RQ10: Four-wire rise with data high tristates, converts.
// RQ11: Four-wire host restores data input within window.
// RQ12: Four-wire data fall shows MSB, falls shift.
// RQ13: Four-wire release at 16th fall or rise.
// RQ14: Host selects next device after previous released.
// RQ15: Host never lowers both inputs in select mode.
// RQ16: Both inputs low drives data out low.
// RQ17: Daisy host keeps clock low, convert high.
// RQ18: Daisy conversion end loads word, shows MSB.
// RQ19: Daisy falls capture data input and shift.
// RQ20: Host gives sixteen falls per chained device.
// RQ21: Daisy host waits maximum conversion before clocking.
`include "sadc_map.svh"
module sadc_dev #(
  parameter int W = `SADC_WORD_W,
  parameter int CONV_NS = `SADC_TCONV_NS
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  sadc_link_if.dev link,
  input wire logic [W-1:0] sample_i,
  output logic busy_o,
  output logic cs_mode_o
);
  localparam int CONV_RAW = (CONV_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS;
  localparam int CONV_CYC = (CONV_RAW < 1) ? 1 : CONV_RAW;
  // Data input idles high; a zero reset would fake a both-low drive and a data edge.
  localparam logic [2:0] PIN_IDLE = `SADC_PIN_IDLE;

  logic [2:0] pins;
  logic [2:0] sy1_ff;
  logic [2:0] sy2_ff;
  logic [2:0] sy3_ff;
  logic [2:0] flt_ff;
  logic [2:0] prv_ff;
  logic cnv_f;
  logic din_f;
  logic cnv_rise;
  logic cnv_fall;
  logic din_rise;
  logic din_fall;
  logic sck_fall;
  logic both_low;
  logic rd_open;
  logic conv_end;

  sadc_pkg::sadc_dev_st_t st_ff;
  logic [15:0] cnt_ff;
  logic cs_mode_ff;
  logic busy_ff;
  logic [W-1:0] smp_ff;
  logic [W-1:0] sh_ff;
  logic [4:0] bit_ff;
  logic oe_ff;
  logic dout_ff;
  logic low_ff;

  // Pin order in the vectors follows the header positions.
  always_comb begin
    pins = 3'h0;
    pins[`SADC_IX_CNV] = link.convert;
    pins[`SADC_IX_DIN] = link.din;
    pins[`SADC_IX_SCK] = link.sclk;
  end

  // Three-stage synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sy1_ff <= PIN_IDLE;
      sy2_ff <= PIN_IDLE;
      sy3_ff <= PIN_IDLE;
    end else begin
      sy1_ff <= pins;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  // A pin change counts only once the second and third stages agree.
  for (genvar g = 0; g < 3; g++) begin : g_flt
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        flt_ff[g] <= PIN_IDLE[g];
        prv_ff[g] <= PIN_IDLE[g];
      end else begin
        if (sy2_ff[g] == sy3_ff[g]) begin
          flt_ff[g] <= sy3_ff[g];
        end
        prv_ff[g] <= flt_ff[g];
      end
    end
  end

  // Edges are seen on the filtered levels, so all pins share one delay.
  assign cnv_f = flt_ff[`SADC_IX_CNV];
  assign din_f = flt_ff[`SADC_IX_DIN];
  assign cnv_rise = cnv_f && !prv_ff[`SADC_IX_CNV];
  assign cnv_fall = !cnv_f && prv_ff[`SADC_IX_CNV];
  assign din_rise = din_f && !prv_ff[`SADC_IX_DIN];
  assign din_fall = !din_f && prv_ff[`SADC_IX_DIN];
  assign sck_fall = !flt_ff[`SADC_IX_SCK] && prv_ff[`SADC_IX_SCK];
  assign both_low = !cnv_f && !din_f;
  assign conv_end = (st_ff == sadc_pkg::SADC_DS_CONV) && (cnt_ff == 16'(CONV_CYC - 1));

  // Output opens on convert fall with data high, or data fall with convert high.
  assign rd_open = (cnv_fall && din_f) || (din_fall && cnv_f); // [RQ7] [RQ12]

  // Phase sequencing and the internal conversion timer.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= sadc_pkg::SADC_DS_IDLE;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end else begin
      case (st_ff)
        sadc_pkg::SADC_DS_IDLE, sadc_pkg::SADC_DS_ACQ: begin
          if (cnv_rise) begin
            st_ff <= sadc_pkg::SADC_DS_CONV; // [RQ4] [RQ10]
            cnt_ff <= 16'h0000;
            busy_ff <= 1'b1;
          end
        end
        sadc_pkg::SADC_DS_CONV: begin
          // Convert, data input and serial clock have no say here.
          cnt_ff <= cnt_ff + 16'h0001; // [RQ2] [RQ5]
          if (conv_end) begin
            st_ff <= sadc_pkg::SADC_DS_ACQ;
            busy_ff <= 1'b0;
          end
        end
        default: begin
          st_ff <= sadc_pkg::SADC_DS_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end

  // Mode and sample are caught together on a convert rise outside conversion.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_mode_ff <= 1'b1;
      smp_ff <= '0;
    end else if (cnv_rise && st_ff != sadc_pkg::SADC_DS_CONV) begin
      cs_mode_ff <= din_f; // [RQ1]
      // The code is kept unsigned: zero at ground, all ones just below reference.
      smp_ff <= sample_i; // [RQ3]
    end
  end

  // Shift register and output pin control for all three link options.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sh_ff <= '0;
      bit_ff <= 5'h00;
      oe_ff <= 1'b0;
      dout_ff <= 1'b0;
      low_ff <= 1'b0;
    end else begin
      if (cnv_rise && st_ff != sadc_pkg::SADC_DS_CONV) begin
        oe_ff <= 1'b0; // [RQ4] [RQ8] [RQ10]
      end else if (conv_end && !cs_mode_ff) begin
        // Daisy mode drives the MSB as soon as the result exists.
        sh_ff <= smp_ff; // [RQ18]
        dout_ff <= smp_ff[W-1];
        oe_ff <= 1'b1;
      end else if (st_ff == sadc_pkg::SADC_DS_ACQ && cs_mode_ff) begin
        if (din_rise) begin
          oe_ff <= 1'b0; // [RQ13]
        end else if (rd_open) begin
          // Reloading from the held result lets a second read start clean.
          sh_ff <= smp_ff;
          dout_ff <= smp_ff[W-1];
          oe_ff <= 1'b1;
          bit_ff <= 5'h00;
        end else if (sck_fall && oe_ff) begin
          sh_ff <= {sh_ff[W-2:0], 1'b0};
          dout_ff <= sh_ff[W-2];
          bit_ff <= bit_ff + 5'h01;
          if (bit_ff == 5'(W - 1)) begin
            oe_ff <= 1'b0; // [RQ8] [RQ13]
          end
        end
      end else if (st_ff == sadc_pkg::SADC_DS_ACQ && sck_fall) begin
        // The upstream device's bit enters at the bottom.
        sh_ff <= {sh_ff[W-2:0], din_f}; // [RQ19]
        dout_ff <= sh_ff[W-2];
      end
      // The forced low is released as soon as either input goes high.
      if (low_ff && !both_low) begin
        low_ff <= 1'b0;
        oe_ff <= 1'b0;
      end
      // Both inputs low wins over everything else.
      if (both_low) begin
        low_ff <= 1'b1; // [RQ16]
        oe_ff <= 1'b1;
        dout_ff <= 1'b0;
      end
    end
  end

  assign link.dout = dout_ff;
  assign link.dout_oe = oe_ff;
  assign busy_o = busy_ff;
  assign cs_mode_o = cs_mode_ff;
endmodule

//--- sadc_fifo.sv
/*
  Word FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
module sadc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic push;
  logic pop;

  // The extra pointer bit tells full from empty without a counter.
  assign in_ready_o = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
  assign out_valid_o = (wr_ff != rd_ff);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_ff[rd_ff[AW-1:0]];

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers advance on accepted transfers.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule

//--- sadc_host.sv
/*
  Host end of the link: starts conversions, waits out the longest
  conversion time, clocks the words in and queues them in a FIFO.
  Assumes one device, or a chain of CHAIN_LEN devices in daisy mode.
*/
`include "sadc_map.svh"
module sadc_host #(
  parameter int W = `SADC_WORD_W,
  parameter int CHAIN_LEN = `SADC_CHAIN_LEN,
  parameter int SCLK_HALF = `SADC_SCLK_HALF,
  parameter int TCONV_MAX_NS = `SADC_TCONV_MAX_NS,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  sadc_link_if.host link,
  input wire logic start_i,
  input wire sadc_pkg::sadc_mode_t mode_i,
  output logic busy_o,
  output logic [W-1:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i
);
  localparam int WAIT_CYC = (TCONV_MAX_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS;

  sadc_pkg::sadc_host_st_t st_ff;
  sadc_pkg::sadc_mode_t mode_ff;
  logic [15:0] tmr_ff;
  logic [4:0] bit_ff;
  logic [7:0] wcnt_ff;
  logic [W-1:0] shin_ff;
  logic cnv_ff;
  logic din_ff;
  logic sck_ff;
  logic busy_ff;
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic sdo_f_ff;
  logic half_hit;
  logic wait_hit;
  logic push;
  logic push_ready;

  assign half_hit = (tmr_ff == 16'(SCLK_HALF - 1));
  assign wait_hit = (tmr_ff == 16'(WAIT_CYC - 1));
  assign push = (st_ff == sadc_pkg::SADC_HS_PUSH);

  // Returned data passes three stages and moves once the last two agree.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      sdo_f_ff <= 1'b0;
    end else begin
      s1_ff <= link.dout_line;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        sdo_f_ff <= s3_ff;
      end
    end
  end

  // Frame sequencing and pin drive; a full FIFO parks the link in PUSH.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= sadc_pkg::SADC_HS_IDLE;
      mode_ff <= sadc_pkg::SADC_MODE_3W;
      tmr_ff <= 16'h0000;
      bit_ff <= 5'h00;
      wcnt_ff <= 8'h00;
      shin_ff <= '0;
      cnv_ff <= 1'b0;
      din_ff <= 1'b1;
      sck_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      tmr_ff <= tmr_ff + 16'h0001;
      case (st_ff)
        sadc_pkg::SADC_HS_IDLE: begin
          tmr_ff <= 16'h0000;
          if (start_i) begin
            mode_ff <= mode_i;
            // Data input settles before convert rises to pick the mode.
            din_ff <= (mode_i != sadc_pkg::SADC_MODE_DAISY); // [RQ1] [RQ15]
            busy_ff <= 1'b1;
            st_ff <= sadc_pkg::SADC_HS_PRE;
          end
        end
        sadc_pkg::SADC_HS_PRE: begin
          if (half_hit) begin
            cnv_ff <= 1'b1; // [RQ17]
            tmr_ff <= 16'h0000;
            st_ff <= sadc_pkg::SADC_HS_CONV;
          end
        end
        sadc_pkg::SADC_HS_CONV: begin
          // Pins stay put for the longest conversion; clock stays low.
          if (wait_hit) begin // [RQ6] [RQ11] [RQ21]
            if (mode_ff == sadc_pkg::SADC_MODE_3W) begin
              cnv_ff <= 1'b0;
            end else if (mode_ff == sadc_pkg::SADC_MODE_4W) begin
              din_ff <= 1'b0; // [RQ9]
            end
            tmr_ff <= 16'h0000;
            bit_ff <= 5'h00;
            wcnt_ff <= 8'h00;
            st_ff <= sadc_pkg::SADC_HS_SEL;
          end
        end
        sadc_pkg::SADC_HS_SEL, sadc_pkg::SADC_HS_LOW: begin
          if (half_hit) begin
            sck_ff <= 1'b1;
            tmr_ff <= 16'h0000;
            st_ff <= sadc_pkg::SADC_HS_HIGH;
          end
        end
        sadc_pkg::SADC_HS_HIGH: begin
          // Sampling just before the fall leaves a full period for the bit.
          if (half_hit) begin
            shin_ff <= {shin_ff[W-2:0], sdo_f_ff};
            sck_ff <= 1'b0;
            tmr_ff <= 16'h0000;
            bit_ff <= bit_ff + 5'h01;
            st_ff <= (bit_ff == 5'(W - 1)) ? sadc_pkg::SADC_HS_PUSH : sadc_pkg::SADC_HS_LOW;
          end
        end
        sadc_pkg::SADC_HS_PUSH: begin
          tmr_ff <= 16'h0000;
          if (push_ready) begin
            bit_ff <= 5'h00;
            wcnt_ff <= wcnt_ff + 8'h01;
            if (mode_ff == sadc_pkg::SADC_MODE_DAISY && wcnt_ff != 8'(CHAIN_LEN - 1)) begin
              st_ff <= sadc_pkg::SADC_HS_LOW; // [RQ20]
            end else begin
              din_ff <= (mode_ff != sadc_pkg::SADC_MODE_DAISY); // [RQ13] [RQ14]
              st_ff <= sadc_pkg::SADC_HS_END;
            end
          end
        end
        sadc_pkg::SADC_HS_END: begin
          // Outside daisy mode the data input is high again before convert drops.
          if (half_hit) begin
            cnv_ff <= 1'b0; // [RQ15]
            busy_ff <= 1'b0;
            st_ff <= sadc_pkg::SADC_HS_IDLE;
          end
        end
        default: begin
          st_ff <= sadc_pkg::SADC_HS_IDLE;
        end
      endcase
    end
  end

  sadc_fifo #(
    .W(W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(push),
    .in_ready_o(push_ready),
    .in_data_i(shin_ff),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i),
    .out_data_o(word_o)
  );

  assign link.convert = cnv_ff;
  assign link.din = din_ff;
  assign link.sclk = sck_ff;
  assign busy_o = busy_ff;
endmodule

//--- sadc_link_if.sv
/*
  The serial link between host and converter: convert, data in, serial
  clock and the tri-state data out with its enable.
  Assumes the bench joins one host and one device through it.
*/
interface sadc_link_if;
  logic convert;
  logic din;
  logic sclk;
  logic dout;
  logic dout_oe;
  logic dout_line;

  // Resolved line level; an undriven line is taken as pulled high.
  assign dout_line = dout_oe ? dout : 1'b1;

  modport dev (
    input convert,
    input din,
    input sclk,
    output dout,
    output dout_oe
  );

  modport host (
    output convert,
    output din,
    output sclk,
    input dout_line
  );
endinterface

//--- sadc_link_properties.sv
/*
  Concurrent checks on the converter link between one host and one converter.
  Assumes plain link signals, the system clock and the active-low reset.
*/
module sadc_link_properties #(
  parameter int CONV_CYC = 10,
  parameter int MAX_CYC = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic convert,
  input wire logic din,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic dout_line
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOAD_DLY = CONV_CYC + 8;
  logic cs_mode_ff;
  logic [3:0] fall_cnt_ff;
  logic [7:0] conv_age_ff;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // Mirror of the mode choice, the falls of one read and the age of the conversion.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cs_mode_ff <= 1'b1;
      fall_cnt_ff <= 4'h0;
      conv_age_ff <= 8'hFF;
    end else begin
      if ($rose(convert)) begin
        cs_mode_ff <= din;
        conv_age_ff <= 8'h00;
      end else if (conv_age_ff != 8'hFF) begin
        conv_age_ff <= conv_age_ff + 8'h01;
      end
      if ($rose(dout_oe)) begin
        fall_cnt_ff <= 4'h0;
      end else if ($fell(sclk) && dout_oe) begin
        fall_cnt_ff <= fall_cnt_ff + 4'h1;
      end
    end
  end

  // The pins pass three sync stages, so answers are given a few cycles of slack.
  sequence s_open;
    ##[3:6] dout_oe;
  endsequence
  sequence s_both_low;
    (!convert && !din) [*8];
  endsequence

  chk_rise_tristate: assert property ($rose(convert) && din |-> ##[3:6] !dout_oe)
    else $error("output still driven after a select-mode convert rise");
  chk_open_three_wire: assert property ($fell(convert) && din |-> s_open)
    else $error("output not opened by a convert fall");
  chk_open_four_wire: assert property ($fell(din) && convert |-> s_open)
    else $error("output not opened by a data input fall");
  chk_release_sixteenth: assert property (cs_mode_ff && $fell(sclk) && dout_oe &&
      fall_cnt_ff == 4'hF |-> ##[3:7] !dout_oe)
    else $error("output not released after the sixteenth fall");
  chk_both_low_drive: assert property (s_both_low |-> dout_oe && !dout && !dout_line)
    else $error("output not driven low with both inputs low");
  chk_daisy_load: assert property ($rose(convert) && !din |-> ##LOAD_DLY dout_oe)
    else $error("chain word not presented after conversion");
  chk_sclk_wait: assert property ($fell(sclk) |-> conv_age_ff >= MAX_CYC)
    else $error("serial clock fell inside the conversion time");
  chk_sclk_idle: assert property ($rose(convert) |-> !sclk)
    else $error("serial clock high at convert rise");
  chk_convert_hold: assert property ($rose(convert) |=> convert [*8])
    else $error("convert dropped during conversion");
  chk_select_fall: assert property (cs_mode_ff && $fell(convert) |-> din)
    else $error("convert and data input low together in select mode");
endmodule

//--- sadc_map.svh
/*
  Constants for the converter control link: word width, pin order in the
  synchroniser vectors, timing figures and the counts derived from them.
  Assumes that it is included by every design file that needs a figure.
*/
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// Result word width, chain length and host FIFO depth.
`define SADC_WORD_W 16
`define SADC_CHAIN_LEN 1
`define SADC_FIFO_DEPTH 16

// Bit positions of the link pins inside the device synchroniser vectors.
`define SADC_IX_CNV 0
`define SADC_IX_DIN 1
`define SADC_IX_SCK 2

// Idle levels of the link pins as seen by the device synchronisers after reset.
`define SADC_PIN_IDLE (3'h1 << `SADC_IX_DIN)

// System clock period and conversion timing in nanoseconds.
`define SADC_CLK_NS 50
`define SADC_TCONV_NS 4000
`define SADC_TCONV_MAX_NS 4400

// Conversion times in clock cycles, rounded up.
`define SADC_TCONV_CYC ((`SADC_TCONV_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_TCONV_MAX_CYC ((`SADC_TCONV_MAX_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)

// Half period of the host serial clock in system clock cycles.
`define SADC_SCLK_HALF 8

`endif

//--- sadc_pkg.sv
/*
  Types shared by both ends of the converter link: host modes and the
  state encodings of both state machines.
  Assumes nothing of its surroundings.
*/
package sadc_pkg;

  // Link options the host can run.
  typedef enum logic [1:0] {
    SADC_MODE_3W = 2'h0,
    SADC_MODE_4W = 2'h1,
    SADC_MODE_DAISY = 2'h2
  } sadc_mode_t;

  // Device phases, Gray coded along idle, convert, acquire.
  typedef enum logic [1:0] {
    SADC_DS_IDLE = 2'h0,
    SADC_DS_CONV = 2'h1,
    SADC_DS_ACQ = 2'h3
  } sadc_dev_st_t;

  // Host frame phases, Gray coded along the usual path except the step from HIGH to PUSH.
  typedef enum logic [2:0] {
    SADC_HS_IDLE = 3'h0,
    SADC_HS_PRE = 3'h1,
    SADC_HS_CONV = 3'h3,
    SADC_HS_SEL = 3'h2,
    SADC_HS_HIGH = 3'h6,
    SADC_HS_LOW = 3'h7,
    SADC_HS_PUSH = 3'h5,
    SADC_HS_END = 3'h4
  } sadc_host_st_t;

endpackage

//--- test_sar_adc_conversion_serial_readout.sv
/*
  Bench joining one host to one converter, plus a second converter driven
  directly by the bench to break and probe the link on purpose.
  Assumes the design files and the checker are compiled before it.
*/
module test_sar_adc_conversion_serial_readout;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i;
  logic reset_n_i;
  logic start;
  sadc_pkg::sadc_mode_t mode;
  logic host_busy, word_valid, word_ready, dev_busy, dev_cs, dev_busy_b, dev_cs_b;
  logic [15:0] word, sample, sample_b, snoop, w;
  int err_count;
  int samples_checked;
  sadc_pkg::sadc_mode_t modes [3] = '{sadc_pkg::SADC_MODE_3W, sadc_pkg::SADC_MODE_4W,
                                       sadc_pkg::SADC_MODE_DAISY};
  logic [15:0] vals [6] = '{16'hFFFF, 16'h0000, 16'h8001, 16'h7FFE, 16'hA5C3, 16'h0001};
  sadc_link_if link ();
  sadc_link_if link_b ();

  sadc_host #(.TCONV_MAX_NS(800)) u_sadc_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .link(link.host), .start_i(start), .mode_i(mode), .busy_o(host_busy), .word_o(word),
    .word_valid_o(word_valid), .word_ready_i(word_ready));
  sadc_dev #(.CONV_NS(500)) u_sadc_dev (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .link(link.dev), .sample_i(sample), .busy_o(dev_busy), .cs_mode_o(dev_cs));
  sadc_dev #(.CONV_NS(2000)) u_sadc_dev_b (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .link(link_b.dev), .sample_i(sample_b), .busy_o(dev_busy_b), .cs_mode_o(dev_cs_b));
  sadc_link_properties #(.CONV_CYC(10), .MAX_CYC(16)) u_sadc_link_properties (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .convert(link.convert), .din(link.din),
    .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe), .dout_line(link.dout_line));

  // System clock of 50 ns.
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Independent listener on the wire: bits as they stand at each serial clock fall.
  always @(negedge link.sclk) snoop <= {snoop[14:0], link.dout_line};

  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // One host frame; the wait is bounded so a stalled host cannot hang the run.
  task automatic frame(input sadc_pkg::sadc_mode_t m, input logic [15:0] s, input int lim);
    int n;
    @(negedge clk_sys_i);
    sample = s;
    mode = m;
    start = 1'b1;
    @(negedge clk_sys_i);
    start = 1'b0;
    n = 0;
    while (host_busy !== 1'b0 && n < lim) begin
      @(negedge clk_sys_i);
      n++;
    end
    // A full frame that runs out of time counts; the short limit probes a stall.
    if (lim > 1000) begin
      cmp_bit("frame finished", 1'b0, host_busy);
    end
  endtask

  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (word_valid !== 1'b1 && n < 1000) begin
      @(negedge clk_sys_i);
      n++;
    end
    cmp_bit("fifo valid", 1'b1, word_valid);
    cmp_word("fifo word", exp, word);
    word_ready = 1'b1;
    @(negedge clk_sys_i);
    // One idle cycle keeps ready from being lowered and raised in one time step.
    word_ready = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic pins_b(input logic c, input logic d);
    @(negedge clk_sys_i);
    link_b.convert = c;
    link_b.din = d;
  endtask

  // Bench-made link clock of 400 ns, only within reads; a bit is taken just before each fall.
  task automatic read_b(input int n, input logic [15:0] d, output logic [15:0] r);
    r = 16'h0000;
    for (int k = 0; k < n; k++) begin
      @(negedge clk_sys_i);
      link_b.sclk = 1'b1;
      link_b.din = d[15-k];
      clks(4);
      r = {r[14:0], link_b.dout_line};
      link_b.sclk = 1'b0;
      clks(3);
    end
  endtask

  // Watchdog well beyond the expected run of about eight thousand cycles.
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    cmp_bit("run finished in time", 1'b1, 1'b0);
    end_of_test();
  end

  initial begin
    reset_n_i = 1'b0;
    start = 1'b0;
    mode = sadc_pkg::SADC_MODE_3W;
    word_ready = 1'b0;
    sample = 16'h0000;
    sample_b = 16'h0000;
    link_b.convert = 1'b0;
    link_b.din = 1'b1;
    link_b.sclk = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    clks(6);
    // Every mode back to back with boundary codes.
    for (int i = 0; i < 6; i++) begin
      frame(modes[i % 3], vals[i], 2000);
      clks(8);
      cmp_word("wire bits", vals[i], snoop);
      cmp_bit("select mode", modes[i % 3] != sadc_pkg::SADC_MODE_DAISY, dev_cs);
      cmp_bit("line driven", modes[i % 3] != sadc_pkg::SADC_MODE_3W, link.dout_oe);
      cmp_bit("converter idle", 1'b0, dev_busy);
      pop(vals[i]);
    end
    // Fill the FIFO until the host must wait, then drain it in order.
    for (int i = 0; i < 16; i++) frame(sadc_pkg::SADC_MODE_4W, 16'h0100 + 16'(i), 2000);
    frame(sadc_pkg::SADC_MODE_4W, 16'hBEEF, 600);
    cmp_bit("host stalled", 1'b1, host_busy);
    for (int i = 0; i < 16; i++) pop(16'h0100 + 16'(i));
    pop(16'hBEEF);
    clks(400);
    cmp_bit("fifo empty", 1'b0, word_valid);
    cmp_bit("host idle", 1'b0, host_busy);
    // Daisy chain on the second converter: both-low drive, load, pass-through.
    sample_b = 16'h5A3C;
    pins_b(1'b0, 1'b0);
    clks(8);
    cmp_bit("both low drive", 1'b1, link_b.dout_oe);
    cmp_bit("both low level", 1'b0, link_b.dout_line);
    pins_b(1'b1, 1'b0);
    clks(50);
    cmp_bit("daisy mode", 1'b0, dev_cs_b);
    cmp_bit("daisy loaded", 1'b1, link_b.dout_oe);
    read_b(16, 16'h0F69, w);
    cmp_word("daisy own word", 16'h5A3C, w);
    read_b(16, 16'h0000, w);
    cmp_word("daisy passed word", 16'h0F69, w);
    // Three-wire with convert dropped and restored during the conversion.
    sample_b = 16'h1234;
    pins_b(1'b0, 1'b1);
    clks(6);
    pins_b(1'b1, 1'b1);
    clks(6);
    pins_b(1'b0, 1'b1);
    clks(8);
    cmp_bit("busy while dropped", 1'b1, dev_busy_b);
    cmp_bit("quiet while dropped", 1'b0, link_b.dout_oe);
    pins_b(1'b1, 1'b1);
    clks(40);
    cmp_bit("conversion over", 1'b0, dev_busy_b);
    cmp_bit("select mode b", 1'b1, dev_cs_b);
    pins_b(1'b0, 1'b1);
    clks(6);
    read_b(16, 16'hFFFF, w);
    cmp_word("three-wire word", 16'h1234, w);
    clks(6);
    cmp_bit("release at last fall", 1'b0, link_b.dout_oe);
    // Four-wire with the select dropped during conversion and an early release.
    sample_b = 16'hC00F;
    pins_b(1'b1, 1'b1);
    clks(6);
    pins_b(1'b1, 1'b0);
    clks(8);
    cmp_bit("four-wire quiet", 1'b0, link_b.dout_oe);
    pins_b(1'b1, 1'b1);
    clks(40);
    pins_b(1'b1, 1'b0);
    clks(6);
    read_b(8, 16'h0000, w);
    cmp_word("four-wire half", 16'h00C0, w);
    pins_b(1'b1, 1'b1);
    clks(6);
    cmp_bit("release at select rise", 1'b0, link_b.dout_oe);
    end_of_test();
  end
endmodule
